// File: src/hsc_defines.svh
/*
  Shared constants of the high speed counter set: stage counts,
  state codes and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

`define HSC_STAGES       6
`define HSC_CNT_W        7
// Shift states are written first stage leftmost: bit 5 is stage 0
`define HSC_SHIFT_RESET  6'h20
`define HSC_ALL_ONES     6'h3f
`define HSC_ALL_ZERO     6'h00
`define HSC_STEP_ONE     6'h10
`define HSC_STEP_TWO     6'h28
// Shift states either side of all ones, first stage leftmost
`define HSC_PRE_ONES     6'h3e
`define HSC_POST_ONES    6'h1f
// Ripple divider value 011111 with lsb leftmost
`define HSC_DIV_ENTRY    6'h3e
`define HSC_MID_ONES     4'hf
`define HSC_PAIRS        3
`define HSC_PAIR_WRAP    2'h1
`define HSC_PAIR_RESET   2'h0
`define HSC_PAIR_CLEAR   6'h00
`define HSC_PAIR_ALL_WRAP 6'h15
`define HSC_PERIOD_63    7'h3f
`define HSC_PERIOD_64    7'h40
`define HSC_CNT_ONE      7'h01

`endif

// File: src/hsc_pkg.sv
/*
  Types of the high speed counter set: stage vectors and the packed
  state records of each module.
  Assumes hsc_defines.svh is on the include path.
*/
`include "hsc_defines.svh"

package hsc_pkg;

  typedef logic [`HSC_STAGES-1:0] hsc_stage_t;
  typedef logic [1:0]             hsc_pair_t;
  typedef logic [`HSC_CNT_W-1:0]  hsc_cnt_t;

  typedef struct packed {
    hsc_stage_t bin;
    hsc_stage_t div;
    logic       div_tc;
  } hsc_top_state_t;

  typedef struct packed {
    hsc_stage_t q;
    logic       tc;
    hsc_cnt_t   steps;
  } hsc_shift_state_t;

  typedef struct packed {
    hsc_pair_t [`HSC_PAIRS-1:0] p;
    logic                       tc;
  } hsc_pair_state_t;

endpackage : hsc_pkg

// File: src/hsc_shift_counter.sv
/*
  Six stage shift counter, 63 states or, with FULL_CYCLE set, 64.
  Assumes count_en_n and restart are synchronous to clk.
*/
`timescale 1ns/100ps
`include "hsc_defines.svh"

module hsc_shift_counter
  import hsc_pkg::*;
#(
  parameter bit FULL_CYCLE = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       count_en_n,
  input  wire logic       restart,
  output hsc_stage_t      state,
  output logic            tc
);

  hsc_shift_state_t st_ff;
  hsc_shift_state_t nxt_st;
  logic             step;
  logic             first;

  assign step  = !count_en_n && !restart;
  assign first = st_ff.q[5];

  always_comb begin
    nxt_st = st_ff;
    if (restart) begin
      nxt_st.q     = `HSC_SHIFT_RESET;
      nxt_st.steps = `HSC_CNT_ONE;
    end else if (step) begin
      nxt_st.q[4:0] = st_ff.q[5:1];
      nxt_st.q[5]   = first ^ !st_ff.q[0];
      if (st_ff.q == `HSC_ALL_ONES)
        nxt_st.q[5] = 1'b0;
      // Splice 111111 in between 111110 and 011111
      if (FULL_CYCLE && first && st_ff.q[4:1] == `HSC_MID_ONES)
        nxt_st.q[5] = !(first ^ !st_ff.q[0]);
      nxt_st.steps = (st_ff.q == `HSC_ALL_ZERO) ? `HSC_CNT_ONE
                   : hsc_cnt_t'(st_ff.steps + 1'b1);
    end
    nxt_st.tc = (nxt_st.q == `HSC_ALL_ZERO);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff.q     <= `HSC_SHIFT_RESET;
      st_ff.tc    <= 1'b0;
      st_ff.steps <= `HSC_CNT_ONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign state = st_ff.q;
  assign tc    = st_ff.tc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_shift_chain_move: assert property (step |=> state[4:0] == $past(state[5:1]))
    else $error("shift chain did not move");
  a_first_stage_flip: assert property (step && !state[0] && !state[5]
    |=> state[5])
    else $error("first stage did not invert");
  a_lockup_exit_zero: assert property (!FULL_CYCLE && step && state == `HSC_ALL_ONES
    |=> !state[5])
    else $error("stuck in all ones");
  a_cycle_length_exact: assert property (step && state == `HSC_ALL_ZERO
    |-> st_ff.steps == (FULL_CYCLE ? `HSC_PERIOD_64 : `HSC_PERIOD_63))
    else $error("cycle length wrong");

endmodule : hsc_shift_counter

// File: src/hsc_pair_counter.sv
/*
  Counter of three count-by-4 shift pairs, 64 states in all.
  Assumes count_en_n and restart are synchronous to clk.
*/
`timescale 1ns/100ps
`include "hsc_defines.svh"

module hsc_pair_counter
  import hsc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 count_en_n,
  input  wire logic                 restart,
  output hsc_pair_t [`HSC_PAIRS-1:0] pairs,
  output logic                      tc
);

  hsc_pair_state_t st_ff;
  hsc_pair_state_t nxt_st;
  logic            step;

  assign step = !count_en_n && !restart;

  always_comb begin
    logic lower_wrap;
    lower_wrap = 1'b1;
    nxt_st     = st_ff;
    for (int k = 0; k < `HSC_PAIRS; k++) begin
      if (restart)
        nxt_st.p[k] = `HSC_PAIR_RESET;
      else if (step && lower_wrap)
        nxt_st.p[k] = {!st_ff.p[k][0], st_ff.p[k][1]};
      lower_wrap = lower_wrap && (st_ff.p[k] == `HSC_PAIR_WRAP);
    end
    nxt_st.tc = 1'b1;
    for (int k = 0; k < `HSC_PAIRS; k++)
      nxt_st.tc = nxt_st.tc && (nxt_st.p[k] == `HSC_PAIR_WRAP);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pairs = st_ff.p;
  assign tc    = st_ff.tc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_upper_pair_hold: assert property (step && pairs[0] != `HSC_PAIR_WRAP
    |=> $stable(pairs[2:1]))
    else $error("upper pair moved early");
  a_low_pair_moves: assert property (step |=> pairs[0] != $past(pairs[0]))
    else $error("low pair stalled");

endmodule : hsc_pair_counter

// File: src/hsc_counter_set.sv
/*
  High speed counter set: synchronous binary counter, divide-by-64
  counter with terminal count, 63 and 64 state shift counters and
  a counter of count-by-4 pairs, all on one clock.
  Assumes count_en_n only changes while the shared clock is high,
  so it is sampled here as a plain synchronous input.
*/
`timescale 1ns/100ps
`include "hsc_defines.svh"

////////////////////////////////////////////////////////////////////

// Summary of operation
// - Binary lsb toggles on every edge with count_en_n and restart low
// - Higher stage toggles when lower stages ones
// - Stage clocks only while its enable low
// - Divider terminal count on 111111 only
// - Shift counter 63 states, invert on zero
// - Later stages load previous stage value
// - All ones state forces first stage zero
// - Counter reset loads 100000
// - All zeros is the terminal shift state
// - This feedback only fits certain lengths
// - Variant includes 111111, 64 states
// - Pair advances when lower pairs 01
// - Outputs change only on clock edge or async reset
module hsc_counter_set
  import hsc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  count_en_n,
  input  wire logic                  restart,
  output hsc_stage_t                 bin_count,
  output hsc_stage_t                 div_count,
  output logic                       div_tc,
  output hsc_stage_t                 shift63_state,
  output logic                       shift63_tc,
  output hsc_stage_t                 shift64_state,
  output logic                       shift64_tc,
  output hsc_pair_t [`HSC_PAIRS-1:0] pair_state,
  output logic                       pair_tc
);

  ////////////////////////////////////////////////////////////////////
  // Per stage enables of the binary counter

  hsc_top_state_t   st_ff;
  hsc_top_state_t   nxt_st;
  hsc_stage_t       stage_en_n;
  logic             step;

  // True when stages below k all hold one
  function automatic logic lower_ones(input hsc_stage_t v, input int k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < `HSC_STAGES; i++)
      if (i < k)
        r = r && v[i];
    return r;
  endfunction : lower_ones

  assign step = !count_en_n && !restart;

  // Each stage sees the shared enable ORed with its own carry term
  genvar g;
  generate
    for (g = 0; g < `HSC_STAGES; g++) begin : g_stage_en
      assign stage_en_n[g] = count_en_n || !lower_ones(st_ff.bin, g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    if (restart) begin
      nxt_st.bin = `HSC_ALL_ZERO;
      nxt_st.div = `HSC_ALL_ZERO;
    end else begin
      for (int k = 0; k < `HSC_STAGES; k++)
        if (!stage_en_n[k])
          nxt_st.bin[k] = !st_ff.bin[k];
      // One clock here, so the ripple chain is kept as a plain increment
      if (step)
        nxt_st.div = hsc_stage_t'(st_ff.div + 1'b1);
    end
    nxt_st.div_tc = (nxt_st.div == `HSC_ALL_ONES);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign bin_count = st_ff.bin;
  assign div_count = st_ff.div;
  assign div_tc    = st_ff.div_tc;

  ////////////////////////////////////////////////////////////////////
  // Shift counters and the pair counter

  hsc_shift_counter #(
    .FULL_CYCLE (1'b0)
  ) u_shift63 (
    .clk        (clk),
    .reset      (reset),
    .count_en_n (count_en_n),
    .restart    (restart),
    .state      (shift63_state),
    .tc         (shift63_tc)
  );

  // Same chain with the modified feedback
  hsc_shift_counter #(
    .FULL_CYCLE (1'b1)
  ) u_shift64 (
    .clk        (clk),
    .reset      (reset),
    .count_en_n (count_en_n),
    .restart    (restart),
    .state      (shift64_state),
    .tc         (shift64_tc)
  );

  hsc_pair_counter u_pairs (
    .clk        (clk),
    .reset      (reset),
    .count_en_n (count_en_n),
    .restart    (restart),
    .pairs      (pair_state),
    .tc         (pair_tc)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_go;
    !count_en_n && !restart;
  endsequence

  sequence s_two_steps;
    restart ##1 s_go ##1 s_go;
  endsequence

  sequence s_div_enter;
    s_go and (div_count == `HSC_DIV_ENTRY);
  endsequence

  sequence s_div_leave;
    s_go and div_tc;
  endsequence

  a_bin_lsb_toggle: assert property (s_go |=> bin_count[0] != $past(bin_count[0]))
    else $error("binary lsb did not toggle");

  a_bin_top_carry: assert property (s_go and bin_count[4:0] == 5'h1f
    |=> bin_count[5] != $past(bin_count[5]))
    else $error("binary msb missed its carry");

  a_bin_top_hold: assert property (bin_count[4:0] != 5'h1f && !restart
    |=> $stable(bin_count[5]))
    else $error("binary msb toggled without carry");

  a_enable_freeze: assert property (count_en_n && !restart
    |=> $stable(bin_count) && $stable(div_count)
        && $stable(shift63_state) && $stable(pair_state))
    else $error("counter moved while disabled");

  a_div_tc_entry: assert property (s_div_enter |=> div_tc)
    else $error("divider terminal count not entered");

  a_div_tc_leave: assert property (s_div_leave
    |=> !div_tc && div_count == `HSC_ALL_ZERO)
    else $error("divider terminal count not left");

  a_div_tc_level: assert property (div_tc == (div_count == `HSC_ALL_ONES))
    else $error("divider terminal count mismatch");

  a_restart_load: assert property (restart
    |=> shift63_state == `HSC_SHIFT_RESET && shift64_state == `HSC_SHIFT_RESET)
    else $error("restart did not load 100000");

  a_shift_first_steps: assert property (s_two_steps
    |-> $past(shift63_state) == `HSC_SHIFT_RESET
    ##1 shift63_state == `HSC_STEP_TWO)
    else $error("shift counter start sequence wrong");

  a_shift_mid_step: assert property (restart ##1 s_go |=> shift63_state == `HSC_STEP_ONE)
    else $error("second shift state wrong");

  a_shift_tc_zero: assert property (shift63_tc == (shift63_state == `HSC_ALL_ZERO))
    else $error("shift terminal flag mismatch");

  a_no_lockup_state: assert property (shift63_state != `HSC_ALL_ONES)
    else $error("63 state counter in all ones");

  ////////////////////////////////////////////////////////////////////
  // Whole-value checks; each wrap is judged at its own end point

  // Low pair in its wrap state 01 lets the pair above it move
  sequence s_low_wrap;
    s_go and (pair_state[0] == `HSC_PAIR_WRAP);
  endsequence

  a_bin_count_step: assert property (s_go
    |=> bin_count == hsc_stage_t'($past(bin_count) + 6'h01))
    else $error("binary counter did not count up");

  a_bin_wrap: assert property (s_go and bin_count == `HSC_ALL_ONES
    |=> bin_count == `HSC_ALL_ZERO)
    else $error("binary counter did not wrap");

  a_div_count_step: assert property (s_go
    |=> div_count == hsc_stage_t'($past(div_count) + 6'h01))
    else $error("divider did not advance");

  a_restart_clears: assert property (restart
    |=> bin_count == `HSC_ALL_ZERO && div_count == `HSC_ALL_ZERO && !div_tc)
    else $error("restart left binary counters set");

  // The divider and pair flags are registered apart from the states, so they get their own freeze check
  a_flags_freeze: assert property (count_en_n && !restart
    |=> $stable(shift64_state) && $stable(div_tc) && $stable(pair_tc))
    else $error("variant or flag moved while disabled");

  // The 63 state chain leaves 111110 straight for 011111
  a_shift63_skip: assert property (s_go and shift63_state == `HSC_PRE_ONES
    |=> shift63_state == `HSC_POST_ONES)
    else $error("63 state counter entered all ones");

  a_shift63_wrap: assert property (s_go and shift63_tc
    |=> shift63_state == `HSC_SHIFT_RESET)
    else $error("63 state counter did not restart its cycle");

  a_shift64_splice: assert property (s_go and shift64_state == `HSC_PRE_ONES
    |=> shift64_state == `HSC_ALL_ONES)
    else $error("64 state counter skipped all ones");

  a_shift64_unlock: assert property (s_go and shift64_state == `HSC_ALL_ONES
    |=> shift64_state == `HSC_POST_ONES)
    else $error("64 state counter stuck in all ones");

  a_shift64_wrap: assert property (s_go and shift64_tc
    |=> shift64_state == `HSC_SHIFT_RESET)
    else $error("64 state counter did not restart its cycle");

  a_shift64_mid_step: assert property (restart ##1 s_go
    |=> shift64_state == `HSC_STEP_ONE)
    else $error("64 state counter second state wrong");

  a_shift64_tc_zero: assert property (shift64_tc == (shift64_state == `HSC_ALL_ZERO))
    else $error("64 state terminal flag mismatch");

  a_restart_flags: assert property (restart
    |=> !shift63_tc && !shift64_tc)
    else $error("restart left a shift terminal flag set");

  a_pair_low_step: assert property (s_go
    |=> pair_state[0] == {!$past(pair_state[0][0]), $past(pair_state[0][1])})
    else $error("low pair left its count-by-4 sequence");

  a_pair_mid_carry: assert property (s_low_wrap and pair_state[1] != `HSC_PAIR_WRAP
    |=> pair_state[1] != $past(pair_state[1]) && $stable(pair_state[2]))
    else $error("middle pair carry wrong");

  a_pair_top_carry: assert property (s_low_wrap and pair_state[1] == `HSC_PAIR_WRAP
    |=> pair_state[2] != $past(pair_state[2]))
    else $error("top pair missed its carry");

  a_pair_wrap: assert property (s_go and pair_tc
    |=> pair_state == `HSC_PAIR_CLEAR)
    else $error("pair counter did not wrap");

  a_pair_restart: assert property (restart
    |=> pair_state == `HSC_PAIR_CLEAR && !pair_tc)
    else $error("restart left pairs set");

  a_pair_tc_level: assert property (pair_tc == (pair_state == `HSC_PAIR_ALL_WRAP))
    else $error("pair terminal flag mismatch");

  // One pair of checks per binary stage, on the same carry decode as the enables
  // Stage 0 never holds while counting, so its hold check stays idle
  generate
    for (g = 0; g < `HSC_STAGES; g++) begin : g_bin_chk
      a_bin_stage_toggle: assert property (s_go and lower_ones(bin_count, g)
        |=> bin_count[g] != $past(bin_count[g]))
        else $error("binary stage missed its toggle");
      a_bin_stage_hold: assert property (!lower_ones(bin_count, g) && !restart
        |=> $stable(bin_count[g]))
        else $error("binary stage toggled without carry");
    end
  endgenerate

endmodule : hsc_counter_set

// File: testbench/hsc_counter_set_tb.sv
/*
  Self-checking bench of the high speed counter set: reset values,
  long enabled walk against reference models, hold, restart, and
  an asynchronous reset in mid-run.
  Assumes the design files and hsc_defines.svh are compiled first.
*/
`timescale 1ns/100ps
`include "hsc_defines.svh"

module hsc_counter_set_tb;
  import hsc_pkg::*;

  logic                       clk;
  logic                       reset;
  logic                       count_en_n;
  logic                       restart;
  hsc_stage_t                 bin_count;
  hsc_stage_t                 div_count;
  logic                       div_tc;
  hsc_stage_t                 shift63_state;
  logic                       shift63_tc;
  hsc_stage_t                 shift64_state;
  logic                       shift64_tc;
  hsc_pair_t [`HSC_PAIRS-1:0] pair_state;
  logic                       pair_tc;
  int                         fail_count;
  int                         compares;
  hsc_stage_t                 e_bin;
  hsc_stage_t                 e_div;
  hsc_stage_t                 e_s63;
  hsc_stage_t                 e_s64;
  hsc_pair_t [`HSC_PAIRS-1:0] e_pr;

  hsc_counter_set dut (
    .clk           (clk),
    .reset         (reset),
    .count_en_n    (count_en_n),
    .restart       (restart),
    .bin_count     (bin_count),
    .div_count     (div_count),
    .div_tc        (div_tc),
    .shift63_state (shift63_state),
    .shift63_tc    (shift63_tc),
    .shift64_state (shift64_state),
    .shift64_tc    (shift64_tc),
    .pair_state    (pair_state),
    .pair_tc       (pair_tc)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic model_reset();
    e_bin = 6'h00;
    e_div = 6'h00;
    e_s63 = `HSC_SHIFT_RESET;
    e_s64 = `HSC_SHIFT_RESET;
    e_pr  = '0;
  endtask : model_reset

  // Reference stepping, all from the old values
  task automatic model_step();
    logic                       lower;
    hsc_pair_t [`HSC_PAIRS-1:0] old;
    e_bin = e_bin + 6'h01;
    e_div = e_div + 6'h01;
    if (e_s63 == 6'h3f) e_s63 = {1'b0, e_s63[5:1]};
    else e_s63 = {e_s63[5] ^ ~e_s63[0], e_s63[5:1]};
    e_s64 = {e_s64[5] ^ ~e_s64[0] ^ (e_s64[5] & (e_s64[4:1] == 4'hf)), e_s64[5:1]};
    old   = e_pr;
    lower = 1'b1;
    for (int k = 0; k < `HSC_PAIRS; k++) begin
      if (lower) e_pr[k] = {~old[k][0], old[k][1]};
      lower = lower & (old[k] == 2'h1);
    end
  endtask : model_step

  task automatic check_all();
    chk({2'h0, bin_count}, {2'h0, e_bin}, "bin_count");
    chk({2'h0, div_count}, {2'h0, e_div}, "div_count");
    chk({7'h00, div_tc}, {7'h00, e_div == 6'h3f}, "div_tc");
    chk({2'h0, shift63_state}, {2'h0, e_s63}, "shift63_state");
    chk({7'h00, shift63_tc}, {7'h00, e_s63 == 6'h00}, "shift63_tc");
    chk({2'h0, shift64_state}, {2'h0, e_s64}, "shift64_state");
    chk({7'h00, shift64_tc}, {7'h00, e_s64 == 6'h00}, "shift64_tc");
    chk({2'h0, pair_state}, {2'h0, e_pr}, "pair_state");
    chk({7'h00, pair_tc}, {7'h00, e_pr == 6'h15}, "pair_tc");
  endtask : check_all

  // Drive at the small offset after an edge, then judge the next edge
  // The offset falls in the high half of the clock, where the enable may move
  task automatic clock_in(input logic en_n, input logic rs);
    count_en_n = en_n;
    restart    = rs;
    @(posedge clk);
    #1;
    if (rs) model_reset();
    else if (!en_n) model_step();
    check_all();
  endtask : clock_in

  ////////////////////////////////////////////////////////////////////

  task automatic t_reset();
    repeat (6) @(posedge clk);
    #1;
    // Judged only after clocked reset edges, so no start-up race decides it
    model_reset();
    check_all();
    reset = 1'b0;
    clock_in(1'b1, 1'b0);
  endtask : t_reset

  task automatic t_walk();
    clock_in(1'b0, 1'b0);
    chk({2'h0, shift63_state}, {2'h0, `HSC_STEP_ONE}, "first step");
    clock_in(1'b0, 1'b0);
    chk({2'h0, shift63_state}, {2'h0, `HSC_STEP_TWO}, "second step");
    for (int i = 3; i <= 130; i++) begin
      clock_in(1'b0, 1'b0);
      if (i % 63 == 0) chk({2'h0, shift63_state}, 8'h20, "period 63");
      if (i % 64 == 0) chk({2'h0, shift64_state}, 8'h20, "period 64");
    end
  endtask : t_walk

  task automatic t_hold();
    // Hold mid-sequence; nothing may move while disabled
    for (int i = 0; i < 5; i++) clock_in(1'b1, 1'b0);
    clock_in(1'b0, 1'b0);
  endtask : t_hold

  task automatic t_restart();
    clock_in(1'b0, 1'b1);
    clock_in(1'b0, 1'b0);
    clock_in(1'b0, 1'b1);
  endtask : t_restart

  task automatic t_async();
    for (int i = 0; i < 40; i++) clock_in(1'b0, 1'b0);
    #0.5;
    reset = 1'b1;
    #0.5;
    model_reset();
    // Must clear before the next rising edge arrives
    check_all();
    @(posedge clk);
    #1;
    reset = 1'b0;
    clock_in(1'b0, 1'b0);
  endtask : t_async

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk        = 1'b0;
    reset      = 1'b1;
    count_en_n = 1'b1;
    restart    = 1'b0;
    fail_count = 0;
    compares   = 0;
    #1;
    t_reset();
    t_walk();
    t_hold();
    t_restart();
    t_async();
    end_of_test();
  end

endmodule : hsc_counter_set_tb
